/* rtl/asramc_ctrl.sv */
/*
  Host-side controller for an asynchronous 16K x 4 static memory: turns
  single word requests into select / write strobe / address / data pin cycles.
  Assumes one 25 MHz clock, the memory on the pins, and a testbench that
  resolves the shared data wire from pins_o.data_oe.
*/
// Operation
// - With select held low the address may change as soon as data is valid.
// - The host drives write data only once the memory outputs have turned off.
// - A strobe-ended write needs data set-up and hold around the strobe rising edge.
// - A select-ended write needs set-up and hold around select rising; outputs stay off.
// - The host keeps select or strobe high while the address changes.
// - The host drives select and strobe with clean single transitions.
`timescale 1ns/1ps
module asramc_ctrl
  import asramc_pkg::*;
#(
  parameter int ACC_CYC_P  = asramc_pkg::ACC_CYC,
  parameter int WZ_CYC_P   = asramc_pkg::WZ_CYC,
  parameter int DATA_CYC_P = asramc_pkg::DATA_CYC
) (
  input  wire logic                             clk_sys_i,   // system clock
  input  wire logic                             resetn_i,    // async reset, low
  input  wire logic                             req_i,       // request valid
  input  wire asramc_pkg::asramc_req_s          req_data_i,  // we, address, write data
  output logic                                  ready_o,     // request taken when high
  output logic                                  rvalid_o,    // read data pulse
  output logic      [asramc_pkg::DATA_W-1:0]    rdata_o,     // read data
  output logic                                  wdone_o,     // write done pulse
  output asramc_pkg::asramc_pins_s              pins_o,      // memory pins out
  input  wire logic [asramc_pkg::DATA_W-1:0]    mem_data_i   // memory data pins in
);

  import asramc_pkg::*;

  localparam int RD_WAIT = ACC_CYC_P + SYNC_STG;

  if (RD_WAIT > 7 || WZ_CYC_P < 1 || WZ_CYC_P > 7 || DATA_CYC_P < 1 || DATA_CYC_P > 7)
  begin : g_bad_counts
    $error("asramc_ctrl: cycle counts out of range for 3-bit counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and counter

  asramc_state_e     state_ff;
  asramc_state_e     nxt_state;
  logic [2:0]        cnt_ff;
  logic [DATA_W-1:0] data_sync;
  logic              take;
  logic              rd_done;

  asramc_sync #(
    .WIDTH (DATA_W)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (mem_data_i),
    .sync_o    (data_sync)
  );

  // fixed wait, no dependence on deselect time
  assign rd_done = (state_ff == ST_RD_ACC) && (cnt_ff == 3'(RD_WAIT - 1));
  assign ready_o = (state_ff == ST_IDLE) || rd_done;
  assign take    = req_i && ready_o;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (take)
          nxt_state = req_data_i.we ? ST_WR_ADDR : ST_RD_ACC;
      end
      ST_RD_ACC:
      begin
        if (rd_done)
        begin
          if (take && !req_data_i.we)
            nxt_state = ST_RD_ACC;
          else if (take)
            nxt_state = ST_WR_ADDR;
          else
            nxt_state = ST_IDLE;
        end
      end
      ST_WR_ADDR:  nxt_state = ST_WR_PULSE;
      ST_WR_PULSE:
      begin
        if (cnt_ff == 3'(WZ_CYC_P - 1))
          nxt_state = ST_WR_DATA;
      end
      ST_WR_DATA:
      begin
        if (cnt_ff == 3'(DATA_CYC_P - 1))
          nxt_state = ST_WR_END;
      end
      ST_WR_END:   nxt_state = ST_WR_REL;
      ST_WR_REL:   nxt_state = ST_IDLE;
      default:     nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_ff <= 3'h0;
    else if (nxt_state != state_ff || rd_done)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= cnt_ff + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, all from flops so strobes never glitch

  logic              sel_n_ff;
  logic              wstrobe_n_ff;
  logic              data_oe_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sel_n_ff     <= 1'b1;
      wstrobe_n_ff <= 1'b1;
    end
    else
    begin
      // select low only in access, pulse and data phases; idle is standby
      sel_n_ff     <= !(nxt_state == ST_RD_ACC || nxt_state == ST_WR_PULSE
                        || nxt_state == ST_WR_DATA);
      // strobe falls with select, so memory outputs never turn on
      wstrobe_n_ff <= !(nxt_state == ST_WR_PULSE || nxt_state == ST_WR_DATA
                        || nxt_state == ST_WR_END);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      data_oe_ff <= 1'b0;
    else
      data_oe_ff <= (nxt_state == ST_WR_DATA) || (nxt_state == ST_WR_END);
  end

  // address moves only on a read or on entry to the write address phase
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      addr_ff  <= ADDR_RST;
      wdata_ff <= DATA_RST;
    end
    else if (take)
    begin
      addr_ff  <= req_data_i.addr;
      wdata_ff <= req_data_i.wdata;
    end
  end

  assign pins_o = '{sel_n: sel_n_ff, wstrobe_n: wstrobe_n_ff, word_address: addr_ff,
                    data: wdata_ff, data_oe: data_oe_ff};

  ////////////////////////////////////////////////////////////////////////////
  // answers

  logic [DATA_W-1:0] rdata_ff;
  logic              rvalid_ff;
  logic              wdone_ff;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_ff  <= DATA_RST;
      rvalid_ff <= 1'b0;
      wdone_ff  <= 1'b0;
    end
    else
    begin
      rvalid_ff <= rd_done;
      wdone_ff  <= (state_ff == ST_WR_REL);
      if (rd_done)
        rdata_ff <= data_sync;
    end
  end

  assign rdata_o  = rdata_ff;
  assign rvalid_o = rvalid_ff;
  assign wdone_o  = wdone_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence wr_open_s;
    $fell(wstrobe_n_ff) && $fell(sel_n_ff) && !data_oe_ff;
  endsequence

  sequence wr_close_s;
    ##1 data_oe_ff ##1 (sel_n_ff && !wstrobe_n_ff && data_oe_ff)
    ##1 (wstrobe_n_ff && !data_oe_ff);
  endsequence

  chk_addr_stable: assert property (
    (!sel_n_ff && !wstrobe_n_ff) |-> $stable(addr_ff))
    else $error("address moved during write");

  chk_no_contend: assert property (
    $rose(data_oe_ff) |-> !$past(wstrobe_n_ff) && !wstrobe_n_ff)
    else $error("data driven before memory outputs off");

  chk_write_seq: assert property (
    wr_open_s |-> wr_close_s)
    else $error("write pin sequence broken");

  chk_strobe_hi_sel: assert property (
    $rose(wstrobe_n_ff) |-> sel_n_ff)
    else $error("strobe rose with select low");

  chk_read_pins: assert property (
    (state_ff == ST_RD_ACC) |-> (!sel_n_ff && wstrobe_n_ff && !data_oe_ff))
    else $error("read pins wrong");

  chk_read_time: assert property (
    ($fell(sel_n_ff) && wstrobe_n_ff) |-> ##RD_WAIT rvalid_ff)
    else $error("read answer late or early");

  chk_standby: assert property (
    (state_ff == ST_IDLE) |-> (sel_n_ff && wstrobe_n_ff && !data_oe_ff))
    else $error("not in standby when idle");

  chk_rd_keep_sel: assert property (
    (rd_done && req_i && !req_data_i.we) |=> !sel_n_ff [*2])
    else $error("select dropped between reads");

  chk_clean_sel: assert property (
    $rose(sel_n_ff) |=> sel_n_ff)
    else $error("select pulsed");

endmodule

/* rtl/asramc_pkg.sv */
/*
  Shared constants and carrier types for the host-side controller of an
  asynchronous 16K x 4 static memory.
  Assumes a single 25 MHz system clock; timings are for the slowest grade.
*/
package asramc_pkg;

  localparam int ADDR_W        = 14;
  localparam int DATA_W        = 4;
  localparam int WORDS         = 16384;

  // timing figures in ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_AA_NS       = 70;   // address / select access, max
  localparam int T_WP_NS       = 50;   // write pulse, min
  localparam int T_CW_NS       = 50;   // select to end of write, min
  localparam int T_DS_NS       = 30;   // data set-up to end of write, min
  localparam int T_WZ_NS       = 25;   // strobe to device output off, max

  // least times round up, never below one cycle
  localparam int ACC_CYC  = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW_CYC   = (T_CW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC   = (T_DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WZ_CYC   = (T_WZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STG = 2;

  // cycles with data driven before the write ends
  localparam int DATA_A   = (WP_CYC - WZ_CYC > DS_CYC) ? WP_CYC - WZ_CYC : DS_CYC;
  localparam int DATA_CYC = (CW_CYC - WZ_CYC > DATA_A) ? CW_CYC - WZ_CYC : DATA_A;

  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_WR_ADDR  = 3'h1,
    ST_WR_PULSE = 3'h3,
    ST_WR_DATA  = 3'h2,
    ST_WR_END   = 3'h6,
    ST_WR_REL   = 3'h7,
    ST_RD_ACC   = 3'h4
  } asramc_state_e;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asramc_req_s;

  typedef struct packed {
    logic              sel_n;
    logic              wstrobe_n;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] data;
    logic              data_oe;
  } asramc_pins_s;

endpackage

/* rtl/asramc_sync.sv */
/*
  Two-stage level synchroniser for a bus of pin inputs.
  Assumes the inputs are asynchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module asramc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys_i,  // system clock
  input  wire logic             resetn_i,   // async reset, low
  input  wire logic [WIDTH-1:0] async_i,    // pin level
  output logic      [WIDTH-1:0] sync_o      // synchronised level
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

/* verif/asramc_mem_model.sv */
/*
  Behavioural 16K x 4 asynchronous static memory standing on the pins.
  Assumes the bench resolves the shared data wire from the host enable alone.
*/
`timescale 1ns/1ps
module asramc_mem_model
  import asramc_pkg::*;
(
  input  wire logic [asramc_pkg::ADDR_W-1:0] addr_i,      // word address
  input  wire logic                          sel_n_i,     // select, low
  input  wire logic                          wstrobe_n_i, // write strobe, low
  input  wire logic [asramc_pkg::DATA_W-1:0] wire_i,      // resolved data wire
  input  wire logic                          host_oe_i,   // host drives wire
  output logic      [asramc_pkg::DATA_W-1:0] q_o,         // memory data out
  output logic                               drive_o,     // memory drives wire
  output logic                               fault_o      // pin misuse seen
);
  import asramc_pkg::*;
  logic [DATA_W-1:0] mem [WORDS];
  logic              quiet = 1'b0;
  realtime           t_chg = 0.0;
  int                acc_ns = 60;

  initial
  begin
    fault_o = 1'b0;
    q_o = 4'h5;
    for (int i = 0; i < WORDS; i++)
      mem[i] = i[3:0] ^ i[11:8] ^ 4'h6;
  end
  //////////////////////////////////////////////////////////////////////////////
  assign drive_o = !sel_n_i && wstrobe_n_i && !quiet;
  // zero delay lets every pin of one edge settle before it is judged
  always @(negedge sel_n_i)
  begin
    t_chg = $realtime;
    #0 quiet = !wstrobe_n_i;
  end
  always @(posedge sel_n_i) quiet = 1'b0;
  always @(addr_i or posedge wstrobe_n_i) t_chg = $realtime;
  always @(posedge sel_n_i or posedge wstrobe_n_i)
    #0 if (sel_n_i ^ wstrobe_n_i) mem[addr_i] = wire_i;
  always @(addr_i) #0 if (!sel_n_i && !wstrobe_n_i) fault_o = 1'b1;
  // undriven wire shows a changing pattern, never the last value
  always #1
  begin
    if (drive_o && host_oe_i) fault_o = 1'b1;
    if (drive_o && ($realtime - t_chg >= acc_ns)) q_o = mem[addr_i];
    else q_o = ~q_o;
  end
endmodule

/* verif/asramc_ctrl_bench.sv */
/*
  Self-checking bench for the static memory controller.
  Assumes the memory model on the pins; inputs change on falling edges.
*/
`timescale 1ns/1ps
module asramc_ctrl_bench;
  import asramc_pkg::*;
  localparam logic [ADDR_W-1:0] ADDRS [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
  localparam logic [DATA_W-1:0] DATS  [4] = '{4'h9, 4'hC, 4'h3, 4'hA};
  logic              clk_sys_i;
  logic              resetn_i;
  logic              req_i;
  asramc_req_s       req_data_i;
  logic              ready_o;
  logic              rvalid_o;
  logic [DATA_W-1:0] rdata_o;
  logic              wdone_o;
  asramc_pins_s      pins_o;
  logic [DATA_W-1:0] mem_q;
  logic [DATA_W-1:0] wire_d;
  logic              mem_drv;
  logic              mem_fault;
  logic              drv_seen;
  logic              sel_hi;
  int                failures;
  int                tests_run;

  assign wire_d = pins_o.data_oe ? pins_o.data : mem_q;
  asramc_ctrl dut_u (
    .clk_sys_i  (clk_sys_i),
    .resetn_i   (resetn_i),
    .req_i      (req_i),
    .req_data_i (req_data_i),
    .ready_o    (ready_o),
    .rvalid_o   (rvalid_o),
    .rdata_o    (rdata_o),
    .wdone_o    (wdone_o),
    .pins_o     (pins_o),
    .mem_data_i (wire_d)
  );
  asramc_mem_model mem_u (
    .addr_i      (pins_o.word_address),
    .sel_n_i     (pins_o.sel_n),
    .wstrobe_n_i (pins_o.wstrobe_n),
    .wire_i      (wire_d),
    .host_oe_i   (pins_o.data_oe),
    .q_o         (mem_q),
    .drive_o     (mem_drv),
    .fault_o     (mem_fault)
  );
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] init_val(input logic [ADDR_W-1:0] a);
    return 16'(a[3:0] ^ a[11:8] ^ 4'h6);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic issue(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(negedge clk_sys_i);
    req_i = 1'b1;
    req_data_i = '{we: we, addr: a, wdata: d};
    n = 0;
    while (ready_o !== 1'b1)
    begin
      @(negedge clk_sys_i);
      sel_hi |= pins_o.sel_n;
      n++;
      if (n > 20)
      begin
        failures++;
        finish_test();
      end
    end
    @(posedge clk_sys_i);
  endtask
  task automatic await_done(input logic we, output logic [DATA_W-1:0] q, output int lat);
    logic done;
    lat = 0;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clk_sys_i);
      req_i = 1'b0;
      lat++;
      done = we ? wdone_o : rvalid_o;
      if (!done) sel_hi |= pins_o.sel_n;
      drv_seen |= we & mem_drv;
      if (lat > 20)
      begin
        failures++;
        finish_test();
      end
    end
    q = rdata_o;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    check("idle select", 16'(pins_o.sel_n), 16'h1);
    check("idle strobe", 16'(pins_o.wstrobe_n), 16'h1);
    check("idle host drive", 16'(pins_o.data_oe), 16'h0);
    check("idle ready", 16'(ready_o), 16'h1);
  endtask
  task automatic t_rw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    int                lat;
    drv_seen = 1'b0;
    issue(1'b1, a, d);
    await_done(1'b1, q, lat);
    check("write latency", 16'(lat), 16'h6);
    check("memory drove in write", 16'(drv_seen), 16'h0);
    issue(1'b0, a, 4'h0);
    await_done(1'b0, q, lat);
    check("read latency", 16'(lat), 16'h5);
    check("read back", 16'(q), 16'(d));
    check("standby after read", 16'(pins_o.sel_n), 16'h1);
    issue(1'b0, a ^ 14'h0001, 4'h0);
    await_done(1'b0, q, lat);
    check("neighbour word", 16'(q), init_val(a ^ 14'h0001));
  endtask
  task automatic t_b2b();
    logic [DATA_W-1:0] q;
    int                lat;
    mem_u.acc_ns = 5;
    issue(1'b0, 14'h0123, 4'h0);
    sel_hi = 1'b0;
    issue(1'b0, 14'h0456, 4'h0);
    await_done(1'b0, q, lat);
    check("first of pair", 16'(q), init_val(14'h0123));
    await_done(1'b0, q, lat);
    check("second of pair", 16'(q), init_val(14'h0456));
    check("select held low", 16'(sel_hi), 16'h0);
    mem_u.acc_ns = 65;
    repeat (30) @(negedge clk_sys_i);
    issue(1'b0, 14'h2345, 4'h0);
    await_done(1'b0, q, lat);
    check("read after long idle", 16'(lat), 16'h5);
    check("slow read data", 16'(q), init_val(14'h2345));
  endtask
  task automatic t_reset_mid();
    issue(1'b1, 14'h0777, 4'h5);
    repeat (2) @(negedge clk_sys_i);
    resetn_i = 1'b0;
    req_i = 1'b0;
    #1;
    t_idle();
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    t_rw(14'h0ABC, 4'h3);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    failures = 0;
    tests_run = 0;
    resetn_i = 1'b0;
    req_i = 1'b0;
    req_data_i = '0;
    drv_seen = 1'b0;
    sel_hi = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    t_idle();
    for (int i = 0; i < 4; i++)
      t_rw(ADDRS[i], DATS[i]);
    t_b2b();
    t_reset_mid();
    check("pin misuse", 16'(mem_fault), 16'h0);
    finish_test();
  end
endmodule
